// ### dv/stx_exec_properties.sv
// Purpose: Port level timing and result checks of the execution unit.
// Assumes: Single clock domain with synchronous active low reset.
// Notes: Bound into every instance of the unit.
`timescale 1ns/1ps
module stx_exec_properties #(
    parameter int PC_W = 12
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ins_valid,
    input wire logic [3:0] ins_op,
    input wire logic [7:0] ins_imm,
    input wire logic ins_ready_reg,
    input wire logic discard_reg,
    input wire logic rom_rd_reg,
    input wire logic [PC_W-1:0] rom_addr_reg,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata_reg,
    input wire logic [7:0] acc_out_reg,
    input wire logic zero_flag_reg
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    logic take;
    logic hit_reg;
    logic hit_next;
    logic [7:0] exp_reg;
    logic [7:0] exp_next;
    assign take = ins_valid && ins_ready_reg;
    always_comb
    begin
        hit_next = nrst && take && ins_op == stx_pkg::OP_XOR_IMM;
        exp_next = acc_out_reg ^ ins_imm;
    end
    always_ff @(posedge clock)
    begin
        hit_reg <= hit_next;
        exp_reg <= exp_next;
    end
    sequence s_take_skip;
        take && ins_op inside {stx_pkg::OP_SKIP_NULL, stx_pkg::OP_COPY_SKIP, stx_pkg::OP_SKIP_BIT};
    endsequence
    sequence s_take_tbl;
        take && ins_op inside {stx_pkg::OP_TBL_CUR, stx_pkg::OP_TBL_LAST};
    endsequence
    sequence s_dummy_slot;
        !ins_ready_reg ##1 ins_ready_reg;
    endsequence
    sequence s_rom_steps;
        rom_rd_reg && !ins_ready_reg ##1 !rom_rd_reg && !ins_ready_reg ##1 ins_ready_reg;
    endsequence
    a_skip_dummy_gap: assert property (discard_reg |-> s_dummy_slot) else $error("skip gap wrong");
    a_discard_cause: assert property (discard_reg |-> $past(take) && $past(ins_op) inside
        {stx_pkg::OP_SKIP_NULL, stx_pkg::OP_COPY_SKIP, stx_pkg::OP_SKIP_BIT}) else $error("stray discard");
    a_no_skip_fast: assert property (s_take_skip ##1 !discard_reg |-> ins_ready_reg)
        else $error("no-skip stalled");
    a_copy_skip_acc: assert property (take && ins_op == stx_pkg::OP_COPY_SKIP |=>
        discard_reg == (acc_out_reg == stx_pkg::ZERO_BYTE)) else $error("copy skip mismatch");
    a_table_read_steps: assert property (s_take_tbl |=> s_rom_steps) else $error("table timing");
    a_last_page_addr: assert property (take && ins_op == stx_pkg::OP_TBL_LAST |=>
        rom_addr_reg[PC_W-1:PC_W-4] == stx_pkg::LAST_PAGE) else $error("last page wrong");
    a_xor_imm_result: assert property (hit_reg |-> acc_out_reg == exp_reg &&
        zero_flag_reg == (exp_reg == stx_pkg::ZERO_BYTE)) else $error("xor imm wrong");
    a_flags_kept: assert property (s_take_skip or s_take_tbl |=> $stable(zero_flag_reg))
        else $error("flag changed");
    a_rdata_idle: assert property (!bus_rd |=> bus_rdata_reg == stx_pkg::ZERO_BYTE) else $error("rdata not idle");
endmodule : stx_exec_properties
bind stx_exec stx_exec_properties #(.PC_W(PC_W)) u_stx_exec_properties (.clock(clock), .nrst(nrst),
    .ins_valid(ins_valid), .ins_op(ins_op), .ins_imm(ins_imm), .ins_ready_reg(ins_ready_reg),
    .discard_reg(discard_reg), .rom_rd_reg(rom_rd_reg), .rom_addr_reg(rom_addr_reg), .bus_rd(bus_rd),
    .bus_rdata_reg(bus_rdata_reg), .acc_out_reg(acc_out_reg), .zero_flag_reg(zero_flag_reg));

// ### dv/stx_exec_tb.sv
// Purpose: Self-checking bench of the execution unit.
// Assumes: Results are observed through register reads, the discard pulse and the accumulator and zero flag outputs.
// Notes: Expected values are queued by the driver and popped by the monitor.
`timescale 1ns/1ps
module stx_exec_tb;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic ins_valid = 1'b0;
    logic [3:0] ins_op = 4'h0;
    logic [7:0] ins_addr = 8'h00;
    logic [2:0] ins_bit = 3'h0;
    logic [7:0] ins_imm = 8'h00;
    logic [11:0] pc = 12'h000;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic ins_ready_reg, discard_reg, rom_rd_reg, zero_flag_reg;
    logic [11:0] rom_addr_reg;
    logic [15:0] rom_data;
    logic [7:0] bus_rdata_reg, acc_out_reg, e8;
    logic [31:0] seed = 32'hFBB7;
    logic q_rd_bit, q_tk, e1;
    logic [7:0] q_rd[$];
    logic q_sk[$];
    logic [7:0] q_acc[$];
    logic q_z[$];
    int failures = 0;
    int samples_checked = 0;
    stx_exec #(.PC_W(12), .RAM_WORDS(160)) u_stx_exec (.clock(clock), .nrst(nrst), .ins_valid(ins_valid),
        .ins_op(ins_op), .ins_addr(ins_addr), .ins_bit(ins_bit), .ins_imm(ins_imm), .pc(pc),
        .ins_ready_reg(ins_ready_reg), .discard_reg(discard_reg), .rom_rd_reg(rom_rd_reg),
        .rom_addr_reg(rom_addr_reg), .rom_data(rom_data), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_reg(bus_rdata_reg), .acc_out_reg(acc_out_reg),
        .zero_flag_reg(zero_flag_reg));
    stx_rom_model u_stx_rom_model (.clock(clock), .rom_rd_reg(rom_rd_reg), .rom_addr_reg(rom_addr_reg),
        .rom_data(rom_data));
    always #10 clock = ~clock;
    function automatic logic [7:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : nxt
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clock);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        bus_rd <= 1'b1;
        bus_addr <= a;
        q_rd.push_back(e);
        @(posedge clock);
        bus_rd <= 1'b0;
    endtask : rd
    task automatic ex(input logic [3:0] op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] k,
        input logic sk, input logic [7:0] ea, input logic ez);
        int n;
        n = 0;
        @(negedge clock);
        while (ins_ready_reg !== 1'b1 && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        if (n == 20)
            failures++;
        @(posedge clock);
        ins_valid <= 1'b1;
        ins_op <= op;
        ins_addr <= a;
        ins_bit <= b;
        ins_imm <= k;
        q_sk.push_back(sk);
        q_acc.push_back(ea);
        q_z.push_back(ez);
        @(posedge clock);
        ins_valid <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : ex
    // ----------------------------------------
    // Monitor
    // ----------------------------------------
    always @(posedge clock)
    begin
        q_rd_bit <= bus_rd;
        q_tk <= ins_valid && ins_ready_reg;
        if (q_rd_bit === 1'b1)
        begin
            e8 = q_rd.pop_front();
            samples_checked++;
            if (bus_rdata_reg !== e8)
            begin
                failures++;
                $display("CHECK FAILED %0t read %h want %h", $time, bus_rdata_reg, e8);
            end
        end
        if (q_tk === 1'b1)
        begin
            e1 = q_sk.pop_front();
            samples_checked++;
            if (discard_reg !== e1)
            begin
                failures++;
                $display("CHECK FAILED %0t discard %b want %b", $time, discard_reg, e1);
            end
            e8 = q_acc.pop_front();
            e1 = q_z.pop_front();
            samples_checked++;
            if (acc_out_reg !== e8 || zero_flag_reg !== e1)
            begin
                failures++;
                $display("CHECK FAILED %0t acc %h zero %b want %h %b", $time, acc_out_reg, zero_flag_reg, e8, e1);
            end
        end
    end
    initial
    begin
        #400000;
        failures++;
        end_of_test();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        logic [7:0] a, m, k, s, r, ad, ea;
        logic sk;
        logic [3:0] op;
        logic [11:0] ra;
        logic [15:0] w;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(stx_pkg::OFS_ACC + 8'(i), 8'h00);
        wr(8'hA0, 8'h55);
        rd(8'hA0, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 12; i++)
        begin
            op = 4'(stx_pkg::OP_XOR_MEM + i % 3);
            a = nxt();
            m = (i % 4 == 0) ? a : nxt();
            k = (i % 4 == 0) ? a : nxt();
            s = nxt() & 8'h3F;
            ad = nxt() % 8'hA0;
            wr(ad, m);
            wr(stx_pkg::OFS_ACC, a);
            wr(stx_pkg::OFS_STATUS, s);
            r = (op == stx_pkg::OP_XOR_IMM) ? a ^ k : a ^ m;
            ea = (op == stx_pkg::OP_XOR_TO_MEM) ? a : r;
            ex(op, ad, 3'h0, k, 1'b0, ea, r == 8'h00);
            rd(stx_pkg::OFS_ACC, ea);
            rd(ad, (op == stx_pkg::OP_XOR_TO_MEM) ? r : m);
            rd(stx_pkg::OFS_STATUS, {s[7:3], r == 8'h00, s[1:0]});
        end
        $display("xor test done");
        for (int i = 0; i < 12; i++)
        begin
            op = 4'(stx_pkg::OP_SKIP_NULL + i % 3);
            a = nxt();
            k = nxt();
            m = (i % 2 == 0 && op != stx_pkg::OP_SKIP_BIT) ? 8'h00 : nxt();
            s = nxt() & 8'h3F;
            ad = nxt() % 8'hA0;
            wr(ad, m);
            wr(stx_pkg::OFS_ACC, a);
            wr(stx_pkg::OFS_STATUS, s);
            sk = (op == stx_pkg::OP_SKIP_BIT) ? !m[k[2:0]] : m == 8'h00;
            ea = (op == stx_pkg::OP_COPY_SKIP) ? m : a;
            ex(op, ad, k[2:0], 8'h00, sk, ea, s[2]);
            rd(stx_pkg::OFS_ACC, ea);
            rd(stx_pkg::OFS_STATUS, s);
        end
        $display("skip test done");
        for (int i = 0; i < 6; i++)
        begin
            m = nxt();
            k = nxt();
            a = nxt();
            s = nxt() & 8'h3F;
            ad = nxt() % 8'hA0;
            wr(stx_pkg::OFS_TBL_LO, m);
            wr(stx_pkg::OFS_TBL_HI, k);
            wr(stx_pkg::OFS_CTRL, {7'h00, i % 3 == 1});
            wr(stx_pkg::OFS_STATUS, s);
            wr(stx_pkg::OFS_ACC, k);
            pc <= {a[3:0], a};
            ra = (i % 3 == 0) ? {a[3:0], m} : (i % 3 == 1) ? {k[3:0], m} : {stx_pkg::LAST_PAGE, m};
            w = {ra[11:4] ^ 8'h3C, ra[7:0] ^ 8'hA5};
            op = (i % 3 == 2) ? stx_pkg::OP_TBL_LAST : stx_pkg::OP_TBL_CUR;
            ex(op, ad, 3'h0, 8'h00, 1'b0, k, s[2]);
            wr(stx_pkg::OFS_LATCH, ~w[15:8]);
            rd(ad, w[7:0]);
            rd(stx_pkg::OFS_LATCH, w[15:8]);
            rd(stx_pkg::OFS_STATUS, s);
        end
        $display("table test done");
        ex(stx_pkg::OP_NOP, ad, 3'h0, 8'hFF, 1'b0, k, s[2]);
        rd(stx_pkg::OFS_ACC, k);
        rd(stx_pkg::OFS_STATUS, s);
        $display("no-op test done");
        // A reset in mid-run must bring the accumulator, status, latch and the option bit back.
        wr(stx_pkg::OFS_CTRL, 8'h01);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd(stx_pkg::OFS_ACC, 8'h00);
        rd(stx_pkg::OFS_STATUS, 8'h00);
        rd(stx_pkg::OFS_CTRL, 8'h00);
        rd(stx_pkg::OFS_LATCH, 8'h00);
        ex(stx_pkg::OP_XOR_IMM, 8'h00, 3'h0, 8'h5A, 1'b0, 8'h5A, 1'b0);
        rd(stx_pkg::OFS_ACC, 8'h5A);
        $display("second reset test done");
        repeat (4) @(posedge clock);
        end_of_test();
    end
endmodule : stx_exec_tb

// ### dv/stx_rom_model.sv
// Purpose: Program ROM seen by the execution unit.
// Assumes: Word is valid only in the cycle after a read request.
// Notes: Outside that cycle the data toggles so stale words are never reused.
`timescale 1ns/1ps
module stx_rom_model (
    input wire logic clock,
    input wire logic rom_rd_reg,
    input wire logic [11:0] rom_addr_reg,
    output logic [15:0] rom_data
);
    initial rom_data = 16'hA5A5;
    always @(posedge clock)
        rom_data <= rom_rd_reg ? {rom_addr_reg[11:4] ^ 8'h3C, rom_addr_reg[7:0] ^ 8'hA5} : ~rom_data;
endmodule : stx_rom_model

// ### hdl/stx_exec.sv
// Purpose: Executes the skip tests, table reads and XOR operations of the core.
// Assumes: One instruction per clock as the machine cycle; ROM answers one cycle after a read.
// Notes: Owns data memory, accumulator, status, table pointers and the high-byte latch.
// How it works
// - Null byte test discards the prefetched instruction with a dummy cycle, else one cycle.
// - Copy byte to accumulator, then skip with a dummy cycle when it is null.
// - Bit test skips with a dummy cycle when the chosen bit is clear.
// - High pointer enabled: ROM address uses both pointers; low to memory, high to latch.
// - High pointer disabled: current page plus low pointer; low to memory, high to latch.
// - Last-page read uses page LAST_PAGE (0xB) plus low pointer; same byte placement.
// - XOR of accumulator and memory byte goes into the accumulator.
// - XOR of accumulator and memory byte goes into memory and updates zero flag.
// - XOR of accumulator and instruction constant goes to accumulator, updates zero flag.
`timescale 1ns/1ps
module stx_exec #(
    parameter int PC_W = stx_pkg::PC_W,
    parameter int RAM_WORDS = stx_pkg::RAM_WORDS
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ins_valid,
    input wire logic [3:0] ins_op,
    input wire logic [7:0] ins_addr,
    input wire logic [2:0] ins_bit,
    input wire logic [7:0] ins_imm,
    input wire logic [PC_W-1:0] pc,
    output logic ins_ready_reg,
    output logic discard_reg,
    output logic rom_rd_reg,
    output logic [PC_W-1:0] rom_addr_reg,
    input wire logic [15:0] rom_data,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata_reg,
    output logic [7:0] acc_out_reg,
    output logic zero_flag_reg
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam int HI_W = PC_W - stx_pkg::PAGE_W;

    logic [7:0] ram [RAM_WORDS];
    stx_pkg::stx_state_e state_reg, state_next;
    logic [7:0] acc_reg, acc_next;
    logic [5:0] status_reg, status_next;
    logic [7:0] tbl_lo_reg, tbl_lo_next;
    logic [HI_W-1:0] tbl_hi_reg, tbl_hi_next;
    logic [7:0] latch_reg, latch_next;
    logic hi_en_reg, hi_en_next;
    logic [7:0] dest_reg, dest_next;
    logic ready_next, discard_next, rom_rd_next;
    logic [PC_W-1:0] rom_addr_next;
    logic [7:0] rdata_next;
    logic ram_we;
    logic [7:0] ram_waddr, ram_wdata;
    logic [7:0] mem_byte, xor_b, xor_res;
    logic xor_zero, take;
    logic ram_hit;

    assign take = ins_valid && ins_ready_reg;
    assign mem_byte = (ins_addr <= stx_pkg::RAM_TOP) ? ram[ins_addr] : stx_pkg::ZERO_BYTE;
    assign xor_b = (ins_op == stx_pkg::OP_XOR_IMM) ? ins_imm : mem_byte;
    assign ram_hit = (bus_addr <= stx_pkg::RAM_TOP);

    stx_xor_unit #(
        .W(8)
    ) u_xor (
        .a(acc_reg),
        .b(xor_b),
        .result(xor_res),
        .zero(xor_zero)
    );

    // ----------------------------------------
    // Execution sequencing
    // ----------------------------------------
    // Bus writes to data memory lose to an instruction write in the same
    // cycle; the core owns memory while it executes.
    always_comb
    begin
        state_next = state_reg;
        acc_next = acc_reg;
        status_next = status_reg;
        tbl_lo_next = tbl_lo_reg;
        tbl_hi_next = tbl_hi_reg;
        latch_next = latch_reg;
        hi_en_next = hi_en_reg;
        dest_next = dest_reg;
        discard_next = 1'b0;
        rom_rd_next = 1'b0;
        rom_addr_next = rom_addr_reg;
        ram_we = 1'b0;
        ram_waddr = bus_addr;
        ram_wdata = bus_wdata;
        if (bus_wr)
        begin
            ram_we = ram_hit;
            case (bus_addr)
                stx_pkg::OFS_ACC: acc_next = bus_wdata;
                stx_pkg::OFS_STATUS: status_next = bus_wdata[5:0];
                stx_pkg::OFS_TBL_LO: tbl_lo_next = bus_wdata;
                stx_pkg::OFS_TBL_HI: tbl_hi_next = bus_wdata[HI_W-1:0];
                stx_pkg::OFS_CTRL: hi_en_next = bus_wdata[stx_pkg::CTRL_HI_EN];
                default: ;
            endcase
        end
        case (state_reg)
            stx_pkg::ST_IDLE:
            begin
                if (take)
                begin
                    case (ins_op)
                        stx_pkg::OP_SKIP_NULL:
                        begin
                            if (mem_byte == stx_pkg::ZERO_BYTE)
                            begin
                                discard_next = 1'b1;
                                state_next = stx_pkg::ST_DUMMY;
                            end
                        end
                        stx_pkg::OP_COPY_SKIP:
                        begin
                            acc_next = mem_byte;
                            if (mem_byte == stx_pkg::ZERO_BYTE)
                            begin
                                discard_next = 1'b1;
                                state_next = stx_pkg::ST_DUMMY;
                            end
                        end
                        stx_pkg::OP_SKIP_BIT:
                        begin
                            if (!mem_byte[ins_bit])
                            begin
                                discard_next = 1'b1;
                                state_next = stx_pkg::ST_DUMMY;
                            end
                        end
                        stx_pkg::OP_TBL_CUR:
                        begin
                            rom_rd_next = 1'b1;
                            dest_next = ins_addr;
                            state_next = stx_pkg::ST_ROM;
                            if (hi_en_reg)
                            begin
                                rom_addr_next = {tbl_hi_reg, tbl_lo_reg};
                            end
                            else
                            begin
                                rom_addr_next = {pc[PC_W-1:stx_pkg::PAGE_W], tbl_lo_reg};
                            end
                        end
                        stx_pkg::OP_TBL_LAST:
                        begin
                            rom_rd_next = 1'b1;
                            dest_next = ins_addr;
                            state_next = stx_pkg::ST_ROM;
                            rom_addr_next = {HI_W'(stx_pkg::LAST_PAGE), tbl_lo_reg};
                        end
                        stx_pkg::OP_XOR_MEM, stx_pkg::OP_XOR_IMM:
                        begin
                            acc_next = xor_res;
                            status_next[stx_pkg::ST_ZERO] = xor_zero;
                        end
                        stx_pkg::OP_XOR_TO_MEM:
                        begin
                            ram_we = (ins_addr <= stx_pkg::RAM_TOP);
                            ram_waddr = ins_addr;
                            ram_wdata = xor_res;
                            status_next[stx_pkg::ST_ZERO] = xor_zero;
                        end
                        default: ;
                    endcase
                end
            end
            stx_pkg::ST_DUMMY:
            begin
                state_next = stx_pkg::ST_IDLE;
            end
            stx_pkg::ST_ROM:
            begin
                state_next = stx_pkg::ST_CAPT;
            end
            stx_pkg::ST_CAPT:
            begin
                // Status stays as it is for every table read.
                ram_we = (dest_reg <= stx_pkg::RAM_TOP);
                ram_waddr = dest_reg;
                ram_wdata = rom_data[7:0];
                latch_next = rom_data[15:8];
                state_next = stx_pkg::ST_IDLE;
            end
            default:
            begin
                state_next = stx_pkg::ST_IDLE;
            end
        endcase
        ready_next = (state_next == stx_pkg::ST_IDLE);
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_comb
    begin
        rdata_next = stx_pkg::ZERO_BYTE;
        if (bus_rd)
        begin
            if (ram_hit)
            begin
                rdata_next = ram[bus_addr];
            end
            else
            begin
                case (bus_addr)
                    stx_pkg::OFS_ACC: rdata_next = acc_reg;
                    stx_pkg::OFS_STATUS: rdata_next = {2'h0, status_reg};
                    stx_pkg::OFS_TBL_LO: rdata_next = tbl_lo_reg;
                    stx_pkg::OFS_TBL_HI: rdata_next = 8'(tbl_hi_reg);
                    stx_pkg::OFS_LATCH: rdata_next = latch_reg;
                    stx_pkg::OFS_CTRL: rdata_next = {7'h00, hi_en_reg};
                    default: rdata_next = stx_pkg::ZERO_BYTE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_reg <= stx_pkg::ST_IDLE;
            acc_reg <= stx_pkg::RST_BYTE;
            status_reg <= stx_pkg::RST_STATUS;
            tbl_lo_reg <= stx_pkg::RST_BYTE;
            tbl_hi_reg <= '0;
            latch_reg <= stx_pkg::RST_BYTE;
            hi_en_reg <= stx_pkg::RST_HI_EN;
            dest_reg <= stx_pkg::RST_BYTE;
            ins_ready_reg <= 1'b0;
            discard_reg <= 1'b0;
            rom_rd_reg <= 1'b0;
            rom_addr_reg <= '0;
            bus_rdata_reg <= stx_pkg::RST_BYTE;
            acc_out_reg <= stx_pkg::RST_BYTE;
            zero_flag_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            status_reg <= status_next;
            tbl_lo_reg <= tbl_lo_next;
            tbl_hi_reg <= tbl_hi_next;
            latch_reg <= latch_next;
            hi_en_reg <= hi_en_next;
            dest_reg <= dest_next;
            ins_ready_reg <= ready_next;
            discard_reg <= discard_next;
            rom_rd_reg <= rom_rd_next;
            rom_addr_reg <= rom_addr_next;
            bus_rdata_reg <= rdata_next;
            acc_out_reg <= acc_next;
            zero_flag_reg <= status_next[stx_pkg::ST_ZERO];
        end
    end

    // Memory contents are not cleared by reset, as in the real array.
    always_ff @(posedge clock)
    begin
        if (nrst && ram_we)
        begin
            ram[ram_waddr] <= ram_wdata;
        end
    end

endmodule : stx_exec

// ### hdl/stx_xor_unit.sv
// Purpose: Bytewise exclusive-OR with a zero detect.
// Assumes: Purely combinational; the caller registers the outputs.
// Notes: Shared by all three XOR forms so the zero test is identical.
`timescale 1ns/1ps
module stx_xor_unit #(
    parameter int W = 8
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    output logic [W-1:0] result,
    output logic zero
);

    always_comb
    begin
        result = a ^ b;
        zero = (result == '0);
    end

endmodule : stx_xor_unit

// ### shared/stx_pkg.sv
// Purpose: Shared constants and types for the skip, table read and XOR unit.
// Assumes: 8-bit data path, 12-bit program address, 256-word program pages.
// Notes: Bus offsets and the operation encoding are shared with the bench.
package stx_pkg;

    // ----------------------------------------
    // Sizes and fixed values
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int PAGE_W = 8;
    localparam int RAM_WORDS = 160;
    localparam logic [3:0] LAST_PAGE = 4'hB;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ----------------------------------------
    // Register port offsets
    // ----------------------------------------
    localparam logic [7:0] RAM_TOP = 8'h9F;
    localparam logic [7:0] OFS_ACC = 8'hF0;
    localparam logic [7:0] OFS_STATUS = 8'hF1;
    localparam logic [7:0] OFS_TBL_LO = 8'hF2;
    localparam logic [7:0] OFS_TBL_HI = 8'hF3;
    localparam logic [7:0] OFS_LATCH = 8'hF4;
    localparam logic [7:0] OFS_CTRL = 8'hF5;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int ST_CARRY = 0;
    localparam int ST_AUX = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_OVF = 3;
    localparam int ST_PDOWN = 4;
    localparam int ST_WDT = 5;
    localparam int CTRL_HI_EN = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_STATUS = 6'h00;
    localparam logic RST_HI_EN = 1'b0;

    // ----------------------------------------
    // Operations and states
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_SKIP_NULL = 4'h1,
        OP_COPY_SKIP = 4'h2,
        OP_SKIP_BIT = 4'h3,
        OP_TBL_CUR = 4'h4,
        OP_TBL_LAST = 4'h5,
        OP_XOR_MEM = 4'h6,
        OP_XOR_TO_MEM = 4'h7,
        OP_XOR_IMM = 4'h8
    } stx_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_DUMMY = 2'h1,
        ST_ROM = 2'h2,
        ST_CAPT = 2'h3
    } stx_state_e;

endpackage : stx_pkg
